// >>> test_extended_instruction_decoder.sv
// self-checking testbench of the extended instruction decoder
`timescale 1ns/1ps
module test_extended_instruction_decoder;
  import xdec_pkg::*;
  logic        mclk, rst, cfg, instr_valid, instr_ready, base_valid, std_banked;
  logic [15:0] instr_word;
  logic [7:0]  working_register, std_file_addr, mem_rdata, mem_wdata_q;
  logic [12:0] pc_latch;
  logic [3:0]  bank_select;
  logic [11:0] std_eff_addr_q, mem_addr_q, ptr0, ptr1, ptr2;
  logic        std_indexed_q, mem_we_q, mem_re_q, call_req_q, ret_req_q, ext_active_q, bv;
  logic [20:0] call_target_q;
  int          mismatches, num_checks;

  xdec_core u_xdec_core (.mclk(mclk), .rst(rst), .extended_set_config_bit(cfg),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
    .base_valid(base_valid), .working_register(working_register), .pc_latch(pc_latch),
    .std_file_addr(std_file_addr), .std_banked(std_banked), .bank_select(bank_select),
    .std_eff_addr_q(std_eff_addr_q), .std_indexed_q(std_indexed_q), .mem_rdata(mem_rdata),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q),
    .mem_re_q(mem_re_q), .call_req_q(call_req_q), .call_target_q(call_target_q),
    .ret_req_q(ret_req_q), .ext_active_q(ext_active_q), .indirect_pointer_0(ptr0),
    .indirect_pointer_1(ptr1), .pointer_two(ptr2));

  xdec_mem_model u_xdec_mem_model (.mclk(mclk), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q), .mem_re_q(mem_re_q),
    .mem_rdata(mem_rdata));

  // ****************
  // helpers
  // ****************
  always #25 mclk = ~mclk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [20:0] got, input logic [20:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // offers one word, returns at the negedge of the cycle after it was taken
  task automatic send(input logic [15:0] w, output logic bvo);
    int n;
    n = 0;
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(negedge mclk);
    while (instr_ready !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (instr_ready !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: word never taken", $time);
      finish_test();
    end
    bvo = base_valid;
    @(posedge mclk);
    instr_valid <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic do_reset(input logic c);
    @(posedge mclk);
    rst <= 1'b1;
    cfg <= c;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic xlate(input logic [7:0] f, input logic bk, input logic [3:0] bs,
                       input logic [11:0] ea, input logic ix);
    @(posedge mclk);
    std_file_addr <= f;
    std_banked    <= bk;
    bank_select   <= bs;
    @(posedge mclk);
    @(negedge mclk);
    chk_v(21'(std_eff_addr_q), 21'(ea), "effective address");
    chk_b(std_indexed_q, ix, "indexed flag");
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_ext_off();
    chk_b(ext_active_q, 1'b0, "extension active");
    send(16'hE801, bv);
    chk_b(bv, 1'b1, "add passed to base");
    chk_v(21'(ptr0), 21'h0, "pointer 0 untouched");
    send(16'h0014, bv);
    chk_b(bv, 1'b1, "call passed to base");
    chk_b(call_req_q, 1'b0, "no call");
    xlate(8'h10, 1'b0, 4'h0, 12'h010, 1'b0);
    $display("test extension off done");
  endtask

  task automatic t_pointers();
    chk_b(ext_active_q, 1'b1, "extension active");
    send(16'hE83F, bv);
    chk_b(bv, 1'b0, "extra not passed to base");
    chk_v(21'(ptr0), 21'h03F, "pointer 0 add");
    send(16'hE941, bv);
    chk_v(21'(ptr1), 21'hFFF, "pointer 1 sub wraps");
    chk_v(21'(ptr0), 21'h03F, "pointer 0 kept");
    send(16'hE890, bv);
    chk_v(21'(ptr2), 21'h010, "pointer two add");
    send(16'hEA5A, bv);
    chk_b(mem_we_q, 1'b1, "push write");
    chk_v(21'(mem_addr_q), 21'h010, "push address");
    chk_v(21'(mem_wdata_q), 21'h05A, "push data");
    chk_v(21'(ptr2), 21'h00F, "pointer two decremented");
    $display("test pointers done");
  endtask

  task automatic t_return(input logic [15:0] w, input logic [11:0] p2);
    send(w, bv);
    chk_v(21'(ptr2), 21'(p2), "pointer two");
    chk_b(ret_req_q, 1'b1, "return request");
    chk_b(instr_ready, 1'b0, "second cycle busy");
    @(negedge mclk);
    chk_b(instr_ready, 1'b1, "ready again");
    chk_b(ret_req_q, 1'b0, "return is a pulse");
    $display("test add or sub with return done");
  endtask

  task automatic t_call();
    send(16'h0014, bv);
    chk_b(call_req_q, 1'b1, "call request");
    chk_v(call_target_q, {13'h1ABC, 8'hA5}, "call target");
    chk_b(instr_ready, 1'b0, "second cycle busy");
    @(negedge mclk);
    chk_b(instr_ready, 1'b1, "ready again");
    $display("test call done");
  endtask

  task automatic t_move(input logic [15:0] w1, input logic [15:0] w2,
                        input logic [11:0] src, input logic [11:0] dst);
    send(w1, bv);
    chk_b(bv, 1'b0, "first word kept");
    send(w2, bv);
    chk_b(mem_re_q, 1'b1, "move read");
    chk_v(21'(mem_addr_q), 21'(src), "move source");
    @(negedge mclk);
    chk_b(mem_we_q, 1'b1, "move write");
    chk_v(21'(mem_addr_q), 21'(dst), "move destination");
    chk_v(21'(mem_wdata_q), 21'(src[7:0] ^ 8'h3C), "move data");
    $display("test move done");
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    cfg = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    working_register = 8'hA5;
    pc_latch = 13'h1ABC;
    std_file_addr = 8'h00;
    std_banked = 1'b0;
    bank_select = 4'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_ext_off();
    do_reset(1'b1);
    t_pointers();
    t_return(16'hE8C5, 12'h014);
    t_return(16'hE9C2, 12'h012);
    t_call();
    t_move(16'hEB03, 16'hF123, 12'h015, 12'h123);
    t_move(16'hEB82, 16'hF005, 12'h014, 12'h017);
    xlate(8'h5F, 1'b0, 4'h0, 12'h071, 1'b1);
    xlate(8'h60, 1'b0, 4'h0, 12'h060, 1'b0);
    xlate(8'h80, 1'b0, 4'h0, 12'hF80, 1'b0);
    xlate(8'h20, 1'b1, 4'h3, 12'h320, 1'b0);
    $display("test address translation done");
    finish_test();
  end
endmodule

// >>> xdec_core.sv
// decoder and executor of the extended instruction set
`timescale 1ns/1ps
module xdec_core #(
  parameter int AW   = xdec_pkg::PTR_WIDTH,
  parameter int NPTR = xdec_pkg::PTR_COUNT
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        extended_set_config_bit,
  input  wire logic                        instr_valid,
  input  wire logic [15:0]                 instr_word,
  output logic                             instr_ready,
  output logic                             base_valid,
  input  wire logic [7:0]                  working_register,
  input  wire logic [xdec_pkg::PCLAT_WIDTH-1:0] pc_latch,
  input  wire logic [7:0]                  std_file_addr,
  input  wire logic                        std_banked,
  input  wire logic [3:0]                  bank_select,
  output logic [AW-1:0]                    std_eff_addr_q,
  output logic                             std_indexed_q,
  input  wire logic [7:0]                  mem_rdata,
  output logic [AW-1:0]                    mem_addr_q,
  output logic [7:0]                       mem_wdata_q,
  output logic                             mem_we_q,
  output logic                             mem_re_q,
  output logic                             call_req_q,
  output logic [xdec_pkg::CALL_WIDTH-1:0]  call_target_q,
  output logic                             ret_req_q,
  output logic                             ext_active_q,
  output logic [AW-1:0]                    indirect_pointer_0,
  output logic [AW-1:0]                    indirect_pointer_1,
  output logic [AW-1:0]                    pointer_two
);
  import xdec_pkg::*;

  xdec_state_t state_q;
  xdec_state_t state_d;
  logic        cfg_taken_q;
  logic [6:0]  src_off_q;
  logic        mode_ss_q;
  logic [AW-1:0] dest_q;

  xdec_ptr_if #(.AW(AW), .NPTR(NPTR)) pif ();

  xdec_ptr_file #(.AW(AW), .NPTR(NPTR)) u_ptr (
    .mclk (mclk),
    .rst  (rst),
    .pif  (pif.owner)
  );

  assign indirect_pointer_0 = pif.ptr[0];
  assign indirect_pointer_1 = pif.ptr[1];
  assign pointer_two        = pif.ptr[SEL_PTR_TWO];

  // ***************************************************************
  // configuration capture
  // ***************************************************************
  // the configuration bit is static, so it is latched once after
  // reset release; a later change has no effect until the next reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_taken_q  <= 1'b0;
      ext_active_q <= EXT_RST;
    end else if (!cfg_taken_q) begin
      cfg_taken_q  <= 1'b1;
      ext_active_q <= extended_set_config_bit;
    end
  end

  // ***************************************************************
  // decode
  // ***************************************************************
  wire        st_idle  = (state_q == ST_IDLE);
  wire        st_wait2 = (state_q == ST_WAIT2);
  wire        st_read  = (state_q == ST_READ);
  wire [7:0]  op_hi    = instr_word[15:8];
  wire [1:0]  op_sel   = instr_word[7:6];
  wire [AW-1:0] lit6   = AW'(instr_word[5:0]);

  // with the extension off every word goes to the base decoder
  wire is_add  = ext_active_q && op_hi == OP_PTR_ADD;
  wire is_sub  = ext_active_q && op_hi == OP_PTR_SUB;
  wire is_push = ext_active_q && op_hi == OP_PUSH;
  wire is_move = ext_active_q && op_hi == OP_MOVE;
  wire is_call = ext_active_q && instr_word == OP_CALL_WORKING_REGISTER;
  wire is_ulnk = (is_add || is_sub) && op_sel == SEL_RETURN;
  wire is_ext  = is_add || is_sub || is_push || is_move || is_call;

  assign instr_ready = st_idle || st_wait2;
  wire   fire        = instr_valid && instr_ready;
  wire   idle_go     = fire && st_idle;
  // anything that is not an extra goes to the base decoder
  assign base_valid  = idle_go && !is_ext;

  wire push_go   = idle_go && is_push;
  wire move_go   = idle_go && is_move;
  wire ulnk_go   = idle_go && is_ulnk;
  wire call_go   = idle_go && is_call;
  wire second_go = fire && st_wait2;

  // ***************************************************************
  // pointer arithmetic
  // ***************************************************************
  // extras write only the pointer file and memory; no flag output
  // exists, so status is never disturbed
  wire [1:0]    upd_sel = (is_push || is_ulnk) ? SEL_PTR_TWO : op_sel;
  wire [AW-1:0] upd_old = pif.ptr[upd_sel];
  wire [AW-1:0] upd_val = is_push ? upd_old - AW'(1) :
                          is_add  ? upd_old + lit6 :
                                    upd_old - lit6;

  assign pif.upd_en  = idle_go && (is_add || is_sub || is_push);
  assign pif.upd_sel = upd_sel;
  assign pif.upd_val = upd_val;

  // ***************************************************************
  // sequencing
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (move_go) begin
          state_d = ST_WAIT2;
        end else if (ulnk_go || call_go) begin
          state_d = ST_BUSY2;
        end
      end
      ST_WAIT2: begin
        if (second_go) begin
          state_d = ST_READ;
        end
      end
      ST_READ:  state_d = ST_IDLE;
      ST_BUSY2: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ***************************************************************
  // indexed moves and push
  // ***************************************************************
  wire [AW-1:0] src_addr  = pointer_two + AW'(src_off_q);
  // the second word's upper nibble is not checked; its low bits are used
  wire [AW-1:0] dest_calc = mode_ss_q ? pointer_two + AW'(instr_word[6:0])
                                      : AW'(instr_word[11:0]);

  wire          mem_we_d    = push_go || st_read;
  wire          mem_re_d    = second_go;
  wire [AW-1:0] mem_addr_d  = push_go   ? pointer_two :
                              second_go ? src_addr :
                              st_read   ? dest_q : mem_addr_q;
  wire [7:0]    mem_wdata_d = push_go ? instr_word[7:0] :
                              st_read ? mem_rdata : mem_wdata_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_off_q   <= 7'h00;
      mode_ss_q   <= 1'b0;
      dest_q      <= AW'(PTR_RST);
      mem_addr_q  <= AW'(PTR_RST);
      mem_wdata_q <= 8'h00;
      mem_we_q    <= 1'b0;
      mem_re_q    <= 1'b0;
    end else begin
      if (move_go) begin
        src_off_q <= instr_word[6:0];
        mode_ss_q <= instr_word[MOVE_MODE_BIT];
      end
      if (second_go) begin
        dest_q <= dest_calc;
      end
      mem_addr_q  <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      mem_we_q    <= mem_we_d;
      mem_re_q    <= mem_re_d;
    end
  end

  // ***************************************************************
  // call and return requests
  // ***************************************************************
  // both pulse during the second instruction cycle; a return comes after the
  // pointer two update of its first cycle has landed, a call updates no pointer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      call_req_q    <= 1'b0;
      call_target_q <= '0;
      ret_req_q     <= 1'b0;
    end else begin
      call_req_q <= call_go;
      ret_req_q  <= ulnk_go;
      if (call_go) begin
        call_target_q <= {pc_latch, working_register};
      end
    end
  end

  // ***************************************************************
  // byte-oriented address translation
  // ***************************************************************
  wire std_idx = ext_active_q && !std_banked && std_file_addr <= IDX_LIMIT;
  wire [AW-1:0] std_addr_d =
    std_banked       ? AW'({bank_select, std_file_addr}) :
    std_idx          ? pointer_two + AW'(std_file_addr) :
    std_file_addr[7] ? AW'({ACCESS_HIGH, std_file_addr}) :
                       AW'({ACCESS_LOW, std_file_addr});

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      std_eff_addr_q <= AW'(PTR_RST);
      std_indexed_q  <= 1'b0;
    end else begin
      std_eff_addr_q <= std_addr_d;
      std_indexed_q  <= std_idx;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_CFG_LATCH: assert property (@(posedge mclk) disable iff (rst)
    $rose(cfg_taken_q) |-> ext_active_q == $past(extended_set_config_bit))
    else $error("extension state differs from configuration bit");

  // with the extension off nothing but the base hand-off may happen
  AST_OFF_PLAIN: assert property (@(posedge mclk) disable iff (rst)
    !ext_active_q |-> st_idle && !mem_we_q && !mem_re_q && !call_req_q && !ret_req_q
      && !std_indexed_q && (!instr_valid || base_valid))
    else $error("extra executed while extension is off");

  AST_BASE_SPLIT: assert property (@(posedge mclk) disable iff (rst)
    base_valid |-> !(ext_active_q
      && (instr_word[15:10] == 6'b111010 || instr_word == OP_CALL_WORKING_REGISTER)))
    else $error("extended word handed to base decoder");

  AST_ADD_ONE: assert property (@(posedge mclk) disable iff (rst)
    idle_go && is_add && op_sel == 2'h0 |=>
      indirect_pointer_0 == $past(indirect_pointer_0) + AW'($past(instr_word[5:0]))
      && instr_ready)
    else $error("pointer add wrong or not single cycle");

  AST_SUB_ONE: assert property (@(posedge mclk) disable iff (rst)
    idle_go && is_sub && op_sel == 2'h1 |=>
      indirect_pointer_1 == $past(indirect_pointer_1) - AW'($past(instr_word[5:0]))
      && instr_ready)
    else $error("pointer subtract wrong or not single cycle");

  AST_ULNK: assert property (@(posedge mclk) disable iff (rst)
    ulnk_go |=> ret_req_q && !instr_ready && !mem_we_q ##1 instr_ready && !ret_req_q)
    else $error("pointer two with return not two cycles");

  AST_CALL: assert property (@(posedge mclk) disable iff (rst)
    call_go |=> call_req_q && !instr_ready
      && call_target_q == {$past(pc_latch), $past(working_register)}
      ##1 instr_ready)
    else $error("call through working register wrong");

  AST_MOVE_FILE: assert property (@(posedge mclk) disable iff (rst)
    second_go && !mode_ss_q |=> mem_re_q && mem_addr_q == $past(src_addr)
      ##1 mem_we_q && mem_addr_q == $past(instr_word[11:0], 2)
      && mem_wdata_q == $past(mem_rdata))
    else $error("indexed to file move wrong");

  AST_MOVE_IDX: assert property (@(posedge mclk) disable iff (rst)
    second_go && mode_ss_q |=> mem_re_q ##1 mem_we_q && instr_ready
      && mem_addr_q == $past(pointer_two, 2) + AW'($past(instr_word[6:0], 2)))
    else $error("indexed to indexed move wrong");

  AST_PUSH: assert property (@(posedge mclk) disable iff (rst)
    push_go |=> mem_we_q && mem_addr_q == $past(pointer_two)
      && mem_wdata_q == $past(instr_word[7:0])
      && pointer_two == $past(pointer_two) - AW'(1) && instr_ready)
    else $error("push literal wrong");

  AST_INDEXED: assert property (@(posedge mclk) disable iff (rst)
    ext_active_q && !std_banked && std_file_addr <= IDX_LIMIT |=>
      std_indexed_q && std_eff_addr_q == $past(pointer_two) + AW'($past(std_file_addr)))
    else $error("indexed literal offset address wrong");

  AST_DIRECT: assert property (@(posedge mclk) disable iff (rst)
    !std_banked && std_file_addr > IDX_LIMIT |=> !std_indexed_q
      && std_eff_addr_q[7:0] == $past(std_file_addr))
    else $error("direct access above limit translated");

  AST_CFG_HOLD: assert property (@(posedge mclk) disable iff (rst)
    cfg_taken_q && $past(cfg_taken_q) |-> $stable(ext_active_q))
    else $error("extension state changed without reset");

  AST_WAIT_SECOND: assert property (@(posedge mclk) disable iff (rst)
    st_wait2 && !instr_valid |=> st_wait2 && instr_ready && !mem_re_q && !mem_we_q)
    else $error("move went on without its second word");

  AST_MOVE_TWO: assert property (@(posedge mclk) disable iff (rst)
    second_go |=> !instr_ready && !base_valid ##1 instr_ready)
    else $error("move second cycle not refused");

  AST_BUSY_TWO: assert property (@(posedge mclk) disable iff (rst)
    (ulnk_go || call_go) |=> !instr_ready && !pif.upd_en ##1 st_idle)
    else $error("two-cycle extra not held for one cycle");

  AST_PUSH_ONLY_TWO: assert property (@(posedge mclk) disable iff (rst)
    push_go |=> indirect_pointer_0 == $past(indirect_pointer_0)
      && indirect_pointer_1 == $past(indirect_pointer_1))
    else $error("push touched another pointer");

endmodule

// >>> xdec_mem_model.sv
// data memory model on the far side of the extended instruction decoder
`timescale 1ns/1ps
module xdec_mem_model (
  input  wire logic        mclk,
  input  wire logic [11:0] mem_addr_q,
  input  wire logic [7:0]  mem_wdata_q,
  input  wire logic        mem_we_q,
  input  wire logic        mem_re_q,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last_q;

  // ****************
  // storage
  // ****************
  // preload pattern is address low byte xor 3Ch, mirrored by the bench
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
    last_q = 8'h00;
  end

  always @(posedge mclk) begin
    if (mem_we_q) begin
      mem[mem_addr_q] <= mem_wdata_q;
    end
    if (mem_re_q) begin
      last_q <= mem_rdata;
    end
  end

  // outside a read the bus shows the inverse of the last value, so stale data never matches
  assign mem_rdata = mem_re_q ? mem[mem_addr_q] : ~last_q;
endmodule

// >>> xdec_pkg.sv
// constants, opcodes and types of the extended instruction decoder
package xdec_pkg;

  // ***************************************************************
  // widths and reset values
  // ***************************************************************
  localparam int unsigned PTR_WIDTH   = 12;
  localparam int unsigned PTR_COUNT   = 3;
  localparam int unsigned PCLAT_WIDTH = 13;
  localparam int unsigned CALL_WIDTH  = 21;
  localparam int unsigned BASE_COUNT  = 75;
  localparam logic [11:0] PTR_RST     = 12'h000;
  localparam logic        EXT_RST     = 1'b0;

  // ***************************************************************
  // encodings
  // ***************************************************************
  localparam logic [7:0]  OP_PTR_ADD   = 8'hE8;
  localparam logic [7:0]  OP_PTR_SUB   = 8'hE9;
  localparam logic [7:0]  OP_PUSH      = 8'hEA;
  localparam logic [7:0]  OP_MOVE      = 8'hEB;
  localparam logic [3:0]  OP_SECOND    = 4'hF;
  localparam logic [15:0] OP_CALL_WORKING_REGISTER = 16'h0014;
  localparam logic [1:0]  SEL_RETURN   = 2'h3;
  localparam logic [1:0]  SEL_PTR_TWO  = 2'h2;
  localparam int unsigned MOVE_MODE_BIT = 7;

  // ***************************************************************
  // byte-oriented addressing
  // ***************************************************************
  localparam logic [7:0]  IDX_LIMIT    = 8'h5F;
  localparam logic [3:0]  ACCESS_HIGH  = 4'hF;
  localparam logic [3:0]  ACCESS_LOW   = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WAIT2 = 4'b0010,
    ST_READ  = 4'b0100,
    ST_BUSY2 = 4'b1000
  } xdec_state_t;

endpackage

// >>> xdec_ptr_file.sv
// the indirect pointers, one writer port
`timescale 1ns/1ps
module xdec_ptr_file #(
  parameter int AW   = xdec_pkg::PTR_WIDTH,
  parameter int NPTR = xdec_pkg::PTR_COUNT
) (
  input  wire logic mclk,
  input  wire logic rst,
  xdec_ptr_if.owner pif
);
  import xdec_pkg::*;

  logic [AW-1:0] ptr_q [NPTR];

  // ***************************************************************
  // one register per pointer
  // ***************************************************************
  for (genvar i = 0; i < NPTR; i++) begin : g_ptr
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ptr_q[i] <= AW'(PTR_RST);
      end else if (pif.upd_en && pif.upd_sel == 2'(i)) begin
        ptr_q[i] <= pif.upd_val;
      end
    end
    assign pif.ptr[i] = ptr_q[i];

    // a pointer moves only through the update port
    AST_PTR_HOLD: assert property (@(posedge mclk) disable iff (rst)
      !(pif.upd_en && pif.upd_sel == 2'(i)) |=> ptr_q[i] == $past(ptr_q[i]))
      else $error("pointer changed without an update");
  end

endmodule

// >>> xdec_ptr_if.sv
// carrier between the decoder and its indirect pointer file
`timescale 1ns/1ps
interface xdec_ptr_if #(
  parameter int AW   = 12,
  parameter int NPTR = 3
);
  logic          upd_en;
  logic [1:0]    upd_sel;
  logic [AW-1:0] upd_val;
  logic [AW-1:0] ptr [NPTR];

  modport owner (
    input  upd_en,
    input  upd_sel,
    input  upd_val,
    output ptr
  );

  modport user (
    output upd_en,
    output upd_sel,
    output upd_val,
    input  ptr
  );
endinterface
